/* File: bench/clock_timebase_chk.sv */
// checker for the clock, strobe and timebase block
`timescale 1ns/1ps
`default_nettype none
module clock_timebase_chk
    import clk_tb_pkg::*;
#(
    parameter int unsigned DIVIDE = TB_DIVIDE
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_in_i,
    input wire logic [2:0] cyc_kind_i,
    input wire logic [2:0] t_state_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [IO_ADDR_WIDTH-1:0] io_addr_i,
    input wire logic phi_o,
    input wire logic e_strobe_o,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_hit_o,
    input wire logic [7:0] tb_count_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_rd;
        io_rd_i && !io_wr_i && io_addr_i == TB_OFFSET;
    endsequence
    sequence s_io_nw;
        cyc_kind_i inside {CYC_IO_RD, CYC_IO_WR} && t_state_i == TS_T2 ##1 t_state_i == TS_T3;
    endsequence
    property p_hit;
        s_rd |=> rd_hit_o && rd_data_o == tb_count_o;
    endproperty
    property p_miss;
        !(io_rd_i && !io_wr_i && io_addr_i == TB_OFFSET) |=> !rd_hit_o;
    endproperty
    property p_dec;
        $changed(tb_count_o) |-> tb_count_o == $past(tb_count_o) - 8'h01;
    endproperty
    property p_stand;
        $changed(tb_count_o) |=> $stable(tb_count_o)[*8] ##1 $stable(tb_count_o) ##1 $changed(tb_count_o);
    endproperty
    property p_mem;
        cyc_kind_i inside {CYC_OPCODE, CYC_MEM_RD, CYC_MEM_WR} && t_state_i inside {TS_T2, TS_TW, TS_T3}
            |=> e_strobe_o;
    endproperty
    property p_iow;
        cyc_kind_i inside {CYC_IO_RD, CYC_IO_WR} && t_state_i == TS_TW |=> e_strobe_o;
    endproperty
    property p_io0;
        s_io_nw |=> !e_strobe_o;
    endproperty
    property p_phi;
        $rose(clk_in_i) |-> ##[2:4] $changed(phi_o);
    endproperty
    property p_phi_src;
        $changed(phi_o) |-> $past(clk_in_i, 3) && !$past(clk_in_i, 4);
    endproperty
    a_hit: assert property (p_hit) else $error("read data wrong");
    a_miss: assert property (p_miss) else $error("unexpected read hit");
    a_dec: assert property (p_dec) else $error("count step wrong");
    a_stand: assert property (p_stand) else $error("count interval wrong");
    a_mem: assert property (p_mem) else $error("strobe low in memory cycle");
    a_iow: assert property (p_iow) else $error("strobe low in wait state");
    a_io0: assert property (p_io0) else $error("strobe high in zero wait io");
    a_phi: assert property (p_phi) else $error("divided clock late");
    a_phi_src: assert property (p_phi_src) else $error("divided clock moved without an input rise");
endmodule
bind clock_timebase clock_timebase_chk #(.DIVIDE(DIVIDE)) clock_timebase_chk_inst (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .clk_in_i(clk_in_i), .cyc_kind_i(cyc_kind_i), .t_state_i(t_state_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .phi_o(phi_o), .e_strobe_o(e_strobe_o), .rd_data_o(rd_data_o),
    .rd_hit_o(rd_hit_o), .tb_count_o(tb_count_o));
`default_nettype wire

/* File: bench/clock_timebase_tb_top.sv */
// testbench for the clock, strobe and timebase block
`timescale 1ns/1ps
`default_nettype none
module clock_timebase_tb_top;
    import clk_tb_pkg::*;
    logic clk_sys_i = 0, rst_b_i = 0, clk_in_i = 0, io_stop_mode_i = 0, io_rd_i = 0, io_wr_i = 0;
    logic [2:0] cyc_kind_i = 3'h0, t_state_i = 3'h0;
    logic [7:0] io_addr_i = 8'h00, rd_data_o, tb_count_o;
    logic phi_o, e_strobe_o, rd_hit_o;
    logic [3:0] hi_cycles;
    int errors = 0, cmp_count = 0, edges = 0;
    clock_timebase clock_timebase_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_in_i(clk_in_i),
        .cyc_kind_i(cyc_kind_i), .t_state_i(t_state_i), .io_stop_mode_i(io_stop_mode_i), .io_rd_i(io_rd_i),
        .io_wr_i(io_wr_i), .io_addr_i(io_addr_i), .phi_o(phi_o), .e_strobe_o(e_strobe_o),
        .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .tb_count_o(tb_count_o));
    strobe_periph strobe_periph_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .e_strobe_i(e_strobe_o),
        .hi_cycles_o(hi_cycles));
    initial forever #50 clk_sys_i = ~clk_sys_i;
    initial forever #400 clk_in_i = ~clk_in_i;
    always @(posedge clk_sys_i) if (rst_b_i) edges++;
    initial
    begin
        #400_000;
        errors++;
        complete_run;
    end
    task step;
        @(posedge clk_sys_i);
        #10;
    endtask
    function logic [7:0] exp_cnt;
        exp_cnt = 8'hff - 8'((edges - 1) / TB_DIVIDE);
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // --------------------------------------------
    // scenarios
    // --------------------------------------------
    task t_read;
        io_addr_i = TB_OFFSET;
        io_rd_i = 1;
        repeat (2)
        begin
            step;
            check({7'h0, rd_hit_o}, 8'h01);
            check(rd_data_o, exp_cnt());
        end
        io_addr_i = 8'h19;
        step;
        check({7'h0, rd_hit_o}, 8'h00);
        check(rd_data_o, 8'h00);
        io_rd_i = 0;
        io_wr_i = 1;
        step;
        check({7'h0, rd_hit_o}, 8'h00);
        io_wr_i = 0;
        step;
        check({7'h0, rd_hit_o}, 8'h00);
    endtask
    task t_count;
        io_stop_mode_i = 1;
        repeat (2600)
        begin
            step;
            check(tb_count_o, exp_cnt());
        end
        io_stop_mode_i = 0;
    endtask
    task t_phi;
        logic last;
        logic [7:0] flips;
        flips = 8'h00;
        last = phi_o;
        repeat (16)
        begin
            step;
            if (phi_o !== last)
                flips = flips + 8'h01;
            last = phi_o;
        end
        check(flips, 8'h02);
    endtask
    task bus_cycle(input logic [2:0] k, input int nw, input logic [3:0] exp_hi);
        logic [7:0] hi_n;
        hi_n = 8'h00;
        step;
        cyc_kind_i = k;
        t_state_i = TS_T1;
        for (int i = 0; i < nw + 6; i++)
        begin
            step;
            hi_n = hi_n + {7'h0, e_strobe_o};
            t_state_i = i == 0 ? TS_T2 : i <= nw ? TS_TW : i == nw + 1 ? TS_T3 : TS_NONE;
            if (i > nw + 1) cyc_kind_i = CYC_IDLE;
        end
        check(hi_n, {4'h0, exp_hi});
        if (exp_hi != 4'h0) check({4'h0, hi_cycles}, {4'h0, exp_hi});
    endtask
    initial
    begin
        #250;
        check(tb_count_o, TB_RESET);
        check({6'h0, phi_o, e_strobe_o}, 8'h00);
        #510 rst_b_i = 1;
        t_read;
        t_phi;
        t_count;
        bus_cycle(CYC_OPCODE, 0, 4'h2);
        bus_cycle(CYC_MEM_RD, 1, 4'h3);
        bus_cycle(CYC_MEM_WR, 2, 4'h4);
        bus_cycle(CYC_IO_RD, 1, 4'h2);
        bus_cycle(CYC_IO_RD, 0, 4'h0);
        bus_cycle(CYC_IO_WR, 2, 4'h2);
        bus_cycle(CYC_IO_WR, 0, 4'h0);
        complete_run;
    end
endmodule
`default_nettype wire

/* File: bench/strobe_periph.sv */
// peripheral model measuring strobe high time
`timescale 1ns/1ps
`default_nettype none
module strobe_periph (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic e_strobe_i,
    output logic [3:0] hi_cycles_o
);
    logic [3:0] run_r;
    // decodes no address, so it sees every strobe; latches width on strobe fall
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            run_r <= 4'h0;
            hi_cycles_o <= 4'h0;
        end
        else
        begin
            run_r <= e_strobe_i ? run_r + 4'h1 : 4'h0;
            if (!e_strobe_i && run_r != 4'h0)
            begin
                hi_cycles_o <= run_r;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/clk_tb_pkg.sv */
// constants for the clock, peripheral strobe and timebase counter block
package clk_tb_pkg;

    // ------------------------------------------------------------
    // timebase counter register
    // ------------------------------------------------------------
    localparam int unsigned TB_WIDTH = 8;
    localparam logic [7:0] TB_OFFSET = 8'h18;
    localparam logic [7:0] TB_RESET = 8'hff;
    localparam int unsigned TB_DIVIDE = 10;
    localparam int unsigned IO_ADDR_WIDTH = 8;

    // ------------------------------------------------------------
    // bus cycle description from the sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CYC_IDLE,
        CYC_OPCODE,
        CYC_MEM_RD,
        CYC_MEM_WR,
        CYC_IO_RD,
        CYC_IO_WR
    } cyc_kind_e;

    typedef enum logic [2:0] {
        TS_NONE,
        TS_T1,
        TS_T2,
        TS_TW,
        TS_T3
    } t_state_e;

endpackage

/* File: hw/clock_timebase.sv */
// system clock divider, peripheral enable strobe and timebase read port
`timescale 1ns/1ps
`default_nettype none
module clock_timebase
    import clk_tb_pkg::*;
#(
    parameter int unsigned DIVIDE = TB_DIVIDE
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_in_i,
    input wire logic [2:0] cyc_kind_i,
    input wire logic [2:0] t_state_i,
    input wire logic io_stop_mode_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [IO_ADDR_WIDTH-1:0] io_addr_i,
    output logic phi_o,
    output logic e_strobe_o,
    output logic [7:0] rd_data_o,
    output logic rd_hit_o,
    output logic [7:0] tb_count_o
);

    initial
    begin
        if (DIVIDE < 2)
            $error("clock_timebase: DIVIDE must be at least 2");
        if (IO_ADDR_WIDTH < 8)
            $error("clock_timebase: I/O address narrower than the timebase offset");
        if (TB_WIDTH != 8)
            $error("clock_timebase: timebase read port is 8 bits wide");
    end

    timebase_if tb_bus ();

    // stop mode is not wired to the counter, so it never halts the timebase
    timebase_counter #(
        .DIVIDE(DIVIDE)
    ) u_counter (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tb(tb_bus)
    );

    // ------------------------------------------------------------
    // input clock: synchronise, find rising edges, divide by two
    // ------------------------------------------------------------
    logic clk_in_s1_r;
    logic clk_in_s2_r;
    logic clk_in_d_r;
    logic phi_r;
    logic clk_in_rise;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clk_in_s1_r <= 1'b0;
            clk_in_s2_r <= 1'b0;
            clk_in_d_r <= 1'b0;
        end
        else
        begin
            clk_in_s1_r <= clk_in_i;
            clk_in_s2_r <= clk_in_s1_r;
            clk_in_d_r <= clk_in_s2_r;
        end
    end

    // rising edge seen one stage past the synchroniser
    assign clk_in_rise = clk_in_s2_r && !clk_in_d_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            phi_r <= 1'b0;
        else if (clk_in_rise)
            phi_r <= ~phi_r;
    end

    assign phi_o = phi_r;

    // ------------------------------------------------------------
    // peripheral enable strobe
    // ------------------------------------------------------------
    cyc_kind_e kind;
    t_state_e ts;
    logic mem_cyc;
    logic io_rd_cyc;
    logic io_wr_cyc;
    logic in_t2;
    logic in_tw;
    logic in_t3;
    logic e_nxt;
    logic e_r;

    assign kind = cyc_kind_e'(cyc_kind_i);
    assign ts = t_state_e'(t_state_i);

    // class of the running machine cycle
    always_comb
    begin
        mem_cyc = 1'b0;
        io_rd_cyc = 1'b0;
        io_wr_cyc = 1'b0;
        case (kind)
            CYC_OPCODE, CYC_MEM_RD, CYC_MEM_WR:
                mem_cyc = 1'b1;
            CYC_IO_RD:
                io_rd_cyc = 1'b1;
            CYC_IO_WR:
                io_wr_cyc = 1'b1;
            CYC_IDLE:
                mem_cyc = 1'b0;
            default:
                mem_cyc = 1'b0;
        endcase
    end

    // T state of the running machine cycle
    always_comb
    begin
        in_t2 = 1'b0;
        in_tw = 1'b0;
        in_t3 = 1'b0;
        case (ts)
            TS_T2:
                in_t2 = 1'b1;
            TS_TW:
                in_tw = 1'b1;
            TS_T3:
                in_t3 = 1'b1;
            TS_NONE, TS_T1:
                in_t2 = 1'b0;
            default:
                in_t2 = 1'b0;
        endcase
    end

    always_comb
    begin
        e_nxt = 1'b0;
        if (mem_cyc)
            // high from T2 through T3, each TW in between adds a cycle
            e_nxt = in_t2 || in_tw || in_t3;
        else if (io_rd_cyc)
            // only a TW raises it; without waits it never rises
            e_nxt = in_tw || (e_r && in_t3);
        else if (io_wr_cyc)
            // io write: wait cycles only
            e_nxt = in_tw;
    end

    // registered so every strobe edge lands on a system clock edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            e_r <= 1'b0;
        else
            e_r <= e_nxt;
    end

    assign e_strobe_o = e_r;

    // ------------------------------------------------------------
    // timebase read port; writes to the address are dropped
    // ------------------------------------------------------------
    logic [7:0] rd_data_r;
    logic rd_hit_r;
    logic [7:0] count_r;
    logic addr_hit;
    logic rd_take;

    assign addr_hit = (io_addr_i == TB_OFFSET);
    assign rd_take = io_rd_i && addr_hit && !io_wr_i;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_hit_r <= 1'b0;
        else
            rd_hit_r <= rd_take;
    end

    // the read only samples the count, it never loads it
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_r <= 8'h00;
        else if (rd_take)
            rd_data_r <= tb_bus.count;
        else
            rd_data_r <= 8'h00;
    end

    // copy moves on the tick, one cycle after each decrement
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count_r <= TB_RESET;
        else if (tb_bus.tick)
            count_r <= tb_bus.count;
    end

    assign rd_data_o = rd_data_r;
    assign rd_hit_o = rd_hit_r;
    assign tb_count_o = count_r;

endmodule
`default_nettype wire

/* File: hw/timebase_counter.sv */
// free running down counter with a fixed prescaler
`timescale 1ns/1ps
`default_nettype none
module timebase_counter
    import clk_tb_pkg::*;
#(
    parameter int unsigned DIVIDE = TB_DIVIDE
)
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    timebase_if.src tb
);

    localparam int unsigned PW = $clog2(DIVIDE);
    localparam logic [PW-1:0] PRE_LAST = PW'(DIVIDE - 1);

    initial
    begin
        if (DIVIDE < 2)
            $error("timebase_counter: DIVIDE must be at least 2");
    end

    logic [PW-1:0] pre_r;
    logic [7:0] count_r;
    logic tick_r;

    // ------------------------------------------------------------
    // prescaler: one tick every DIVIDE cycles, never gated
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pre_r <= '0;
            tick_r <= 1'b0;
        end
        else if (pre_r == PRE_LAST)
        begin
            pre_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            pre_r <= pre_r + PW'(1);
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // counter: wraps through zero, no load path at all
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            count_r <= TB_RESET;
        else if (pre_r == PRE_LAST)
            count_r <= count_r - 8'h01;
    end

    assign tb.count = count_r;
    assign tb.tick = tick_r;

endmodule
`default_nettype wire

/* File: hw/timebase_if.sv */
// carrier between the timebase counter and the top module
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic [7:0] count;
    logic tick;

    modport src (
        output count,
        output tick
    );
    modport dst (
        input count,
        input tick
    );
endinterface
`default_nettype wire
